/* cod_decode.sv */
// Purpose: opcode decode slice with operand fetch and register transfers
// Assumes: one instruction byte offered per i_byte_vld pulse
// Notes:   flags are untouched here except o_set_irq_mask on the software trap; execution beyond transfers is outside
`timescale 1ns/10ps
module cod_decode (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  input  wire logic                i_byte_vld,
  input  wire logic [7:0]          i_byte,
  input  wire logic [15:0]         i_index_pair,
  input  wire logic [15:0]         i_stack_ptr,
  output cod_pkg::cod_amode_t      o_amode,
  output cod_pkg::cod_base_t       o_base,
  output cod_pkg::cod_xfer_t       o_xfer,
  output logic [7:0]               o_opcode,
  output logic [3:0]               o_cycles,
  output logic [2:0]               o_bytes,
  output logic [15:0]              o_eff_addr,
  output logic [15:0]              o_xfer_value,
  output logic [7:0]               o_dest_addr,
  output logic                     o_index_inc,
  output logic                     o_set_irq_mask,
  output logic                     o_flags_keep,
  output logic                     o_illegal,
  output logic                     o_done
);
  import cod_pkg::*;

  cod_state_t state_r;
  logic       prefix_r;
  logic [7:0] opc_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic [7:0] b1_r;
  logic [1:0] need_r;
  logic       use_b1_r;
  cod_amode_t rom_amode;
  logic [3:0] rom_cycles;
  logic [2:0] rom_bytes;
  logic       rom_illegal;
  logic [7:0] rom_opc;
  logic       rom_pre;

  assign rom_opc = (state_r == COD_ST_IDLE) ? i_byte : opc_r;
  assign rom_pre = (state_r == COD_ST_IDLE) ? 1'b0 : prefix_r;

  cod_rom u_rom (
    .i_opcode  (rom_opc),
    .i_prefixed(rom_pre),
    .o_amode   (rom_amode),
    .o_cycles  (rom_cycles),
    .o_bytes   (rom_bytes),
    .o_illegal (rom_illegal)
  );

  // operand bytes still to fetch: length less opcode and prefix;
  // counted from length so a branch offset after an address is fetched too
  function automatic logic [1:0] operand_count(input logic [2:0] len, input logic pre);
    logic [2:0] rest;
    rest = len - 3'h1 - {2'b00, pre};
    return rest[1:0];
  endfunction

  logic [1:0] need_now;
  assign need_now = operand_count(rom_bytes, rom_pre);

  default clocking cb_dec @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r  <= COD_ST_IDLE;
      prefix_r <= 1'b0;
      opc_r    <= 8'h00;
      need_r   <= 2'd0;
    end else begin
      case (state_r)
        COD_ST_IDLE: begin
          if (i_byte_vld) begin
            if (i_byte == OPC_STACK_PREFIX && !prefix_r) begin
              prefix_r <= 1'b1;
            end else begin
              opc_r   <= i_byte;
              state_r <= COD_ST_HI;
            end
          end
        end
        COD_ST_HI: begin
          // decode the latched opcode one cycle later
          if (rom_illegal || need_now == 2'd0) begin
            state_r <= COD_ST_DONE;
          end else begin
            need_r  <= need_now;
            state_r <= COD_ST_LO;
          end
        end
        COD_ST_LO: begin
          if (i_byte_vld) begin
            need_r <= need_r - 2'd1;
            if (need_r == 2'd1) begin
              state_r <= COD_ST_DONE;
            end
          end
        end
        COD_ST_DONE: begin
          prefix_r <= 1'b0;
          state_r  <= COD_ST_IDLE;
        end
        default: state_r <= COD_ST_IDLE;
      endcase
    end
  end

  // first operand byte is the high byte of a pair
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hi_r     <= 8'h00;
      lo_r     <= 8'h00;
      b1_r     <= 8'h00;
      use_b1_r <= 1'b0;
    end else if (state_r == COD_ST_HI) begin
      use_b1_r <= 1'b0;
    end else if (state_r == COD_ST_LO && i_byte_vld) begin
      if (need_r == 2'd2) begin
        hi_r     <= i_byte;
        b1_r     <= i_byte;
        use_b1_r <= 1'b1;
      end else begin
        lo_r <= i_byte;
        if (!use_b1_r) begin
          hi_r <= 8'h00;
        end
      end
    end
  end

  logic [15:0] off16;
  assign off16 = {hi_r, lo_r};
  // one-byte address is the first operand; a branch offset may follow it
  logic [7:0]  first_b;
  assign first_b = use_b1_r ? b1_r : lo_r;

  sequence s_pair_hi;
    state_r == COD_ST_LO && i_byte_vld && need_r == 2'd2;
  endsequence
  sequence s_pair_lo;
    state_r == COD_ST_LO && i_byte_vld && need_r == 2'd1;
  endsequence
  property p_high_byte_first;
    s_pair_hi ##1 s_pair_lo |=> off16 == {$past(i_byte, 2), $past(i_byte)};
  endproperty
  a_high_byte_first: assert property (p_high_byte_first) else $error("pair order wrong");

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_amode        <= COD_AM_NONE;
      o_base         <= COD_BASE_NONE;
      o_xfer         <= COD_XF_NONE;
      o_opcode       <= 8'h00;
      o_cycles       <= 4'h0;
      o_bytes        <= 3'h0;
      o_eff_addr     <= 16'h0000;
      o_xfer_value   <= 16'h0000;
      o_dest_addr    <= 8'h00;
      o_index_inc    <= 1'b0;
      o_set_irq_mask <= 1'b0;
      o_flags_keep   <= 1'b0;
      o_illegal      <= 1'b0;
      o_done         <= 1'b0;
    end else begin
      o_done <= (state_r == COD_ST_DONE);
      if (state_r == COD_ST_DONE) begin
        o_opcode       <= opc_r;
        o_amode        <= rom_amode;
        o_cycles       <= rom_cycles;
        o_bytes        <= rom_bytes;
        o_illegal      <= rom_illegal;
        o_index_inc    <= !rom_illegal && (rom_amode == COD_AM_IXP ||
                          rom_amode == COD_AM_IX1P || rom_amode == COD_AM_IXP_DIR);
        o_set_irq_mask <= !rom_illegal && !prefix_r && opc_r == OPC_SOFTWARE_TRAP;
        o_flags_keep   <= !prefix_r && (opc_r == OPC_STACK_TO_INDEX ||
                          opc_r == OPC_INDEX_TO_STACK || opc_r == OPC_INDEX_LOW_TO_ACC);
        o_dest_addr    <= 8'h00;
        o_xfer         <= COD_XF_NONE;
        o_xfer_value   <= 16'h0000;
        o_base         <= COD_BASE_NONE;
        o_eff_addr     <= 16'h0000;
        if (rom_illegal) begin
          o_amode <= COD_AM_ILLEGAL;
        end else begin
          case (rom_amode)
            COD_AM_IX2: begin
              o_base <= COD_BASE_INDEX; o_eff_addr <= i_index_pair + off16;
            end
            COD_AM_IX1, COD_AM_IX1P: begin
              o_base <= COD_BASE_INDEX;
              o_eff_addr <= i_index_pair + {8'h00, first_b};
            end
            COD_AM_IX, COD_AM_IXP, COD_AM_IXP_DIR: begin
              o_base <= COD_BASE_INDEX; o_eff_addr <= i_index_pair;
              o_dest_addr <= (rom_amode == COD_AM_IXP_DIR) ? lo_r : 8'h00;
            end
            COD_AM_SP1: begin
              o_base <= COD_BASE_STACK; o_eff_addr <= i_stack_ptr + {8'h00, first_b};
            end
            COD_AM_SP2: begin
              o_base <= COD_BASE_STACK; o_eff_addr <= i_stack_ptr + off16;
            end
            COD_AM_FULL: begin
              o_eff_addr <= off16;
            end
            COD_AM_PAGE0: begin
              o_base <= COD_BASE_ZERO; o_eff_addr <= {8'h00, first_b};
            end
            COD_AM_LIT_DIR: begin
              o_base <= COD_BASE_ZERO; o_eff_addr <= {8'h00, b1_r};
              o_dest_addr <= lo_r;
            end
            default: begin
            end
          endcase
          if (!prefix_r) begin
            case (opc_r)
              OPC_STACK_TO_INDEX: begin
                o_xfer <= COD_XF_SP_TO_HX; o_xfer_value <= i_stack_ptr + 16'h0001;
              end
              OPC_INDEX_TO_STACK: begin
                o_xfer <= COD_XF_HX_TO_SP; o_xfer_value <= i_index_pair - 16'h0001;
              end
              OPC_INDEX_LOW_TO_ACC: begin
                o_xfer <= COD_XF_XL_TO_ACC; o_xfer_value <= {8'h00, i_index_pair[7:0]};
              end
              OPC_SOFTWARE_TRAP: begin
                o_xfer <= COD_XF_TRAP; o_xfer_value <= COD_VECTOR_ADDR;
                o_eff_addr <= i_stack_ptr - {8'h00, COD_TRAP_SP_DROP};
              end
              default: begin
              end
            endcase
          end
        end
      end
    end
  end

  property p_stack_to_pair;
    state_r == COD_ST_DONE && !prefix_r && opc_r == OPC_STACK_TO_INDEX |=>
      o_done && o_xfer == COD_XF_SP_TO_HX && o_cycles == COD_XFER_CYCLES && o_flags_keep &&
      o_xfer_value == 16'($past(i_stack_ptr) + 16'h0001);
  endproperty
  a_stack_to_pair: assert property (p_stack_to_pair) else $error("stack copy wrong");
  property p_low_to_acc;
    state_r == COD_ST_DONE && !prefix_r && opc_r == OPC_INDEX_LOW_TO_ACC |=>
      o_xfer == COD_XF_XL_TO_ACC && o_cycles == COD_ACC_CYCLES_1 &&
      o_xfer_value == {8'h00, $past(i_index_pair[7:0])};
  endproperty
  a_low_to_acc: assert property (p_low_to_acc) else $error("index low copy wrong");
  property p_pair_to_stack;
    state_r == COD_ST_DONE && !prefix_r && opc_r == OPC_INDEX_TO_STACK |=>
      o_xfer == COD_XF_HX_TO_SP && o_cycles == COD_XFER_CYCLES && o_flags_keep &&
      o_xfer_value == 16'($past(i_index_pair) - 16'h0001);
  endproperty
  a_pair_to_stack: assert property (p_pair_to_stack) else $error("pair copy wrong");
  property p_stack_base;
    state_r == COD_ST_DONE && prefix_r && !rom_illegal |=> o_base == COD_BASE_STACK;
  endproperty
  a_stack_base: assert property (p_stack_base) else $error("stack base wrong");
  property p_trap_masks;
    state_r == COD_ST_DONE && !prefix_r && opc_r == OPC_SOFTWARE_TRAP |=>
      o_set_irq_mask && o_xfer == COD_XF_TRAP && o_xfer_value == COD_VECTOR_ADDR;
  endproperty
  a_trap_masks: assert property (p_trap_masks) else $error("trap outputs wrong");
  property p_illegal_inert;
    state_r == COD_ST_DONE && rom_illegal |=>
      o_illegal && o_amode == COD_AM_ILLEGAL && o_xfer == COD_XF_NONE && !o_index_inc;
  endproperty
  a_illegal_inert: assert property (p_illegal_inert) else $error("illegal opcode acted");
endmodule // cod_decode

/* cod_pkg.sv */
// Purpose: shared constants and types for the opcode decode slice
// Assumes: 8-bit opcodes, one optional stack prefix byte
// Notes:   only rows 0 to 3 of the opcode map plus three transfers and two moves are known
package cod_pkg;
  localparam logic [7:0] OPC_STACK_PREFIX     = 8'h9E;
  localparam logic [7:0] OPC_STACK_TO_INDEX   = 8'h95;
  localparam logic [7:0] OPC_INDEX_LOW_TO_ACC = 8'h9F;
  localparam logic [7:0] OPC_INDEX_TO_STACK   = 8'h94;
  localparam logic [7:0] OPC_RETURN_FROM_IRQ  = 8'h80;
  localparam logic [7:0] OPC_SOFTWARE_TRAP    = 8'h83;
  localparam logic [7:0] OPC_PRODUCT          = 8'h42;
  localparam logic [7:0] OPC_QUOTIENT         = 8'h52;
  localparam logic [7:0] OPC_CMP_BR_EQ_DIR    = 8'h31;
  localparam logic [7:0] OPC_CMP_ACC_BR_EQ    = 8'h41;
  localparam logic [7:0] OPC_MOV_LIT_DIR      = 8'h6E;
  localparam logic [7:0] OPC_MOV_IXP_DIR      = 8'h7E;

  typedef enum logic [3:0] {
    COD_AM_NONE     = 4'h0, // no_operand_mode
    COD_AM_LITERAL  = 4'h1, // literal_operand_mode
    COD_AM_PAGE0    = 4'h2, // page_zero_mode
    COD_AM_FULL     = 4'h3, // full_address_mode
    COD_AM_REL      = 4'h4,
    COD_AM_IX       = 4'h5,
    COD_AM_IX1      = 4'h6,
    COD_AM_IX2      = 4'h7, // index_offset16_mode
    COD_AM_IXP      = 4'h8, // index_postinc_mode
    COD_AM_IX1P     = 4'h9, // index_offset8_postinc_mode
    COD_AM_LIT_DIR  = 4'hA, // literal_to_page_zero_mode
    COD_AM_IXP_DIR  = 4'hB, // index_postinc_to_page_zero_mode
    COD_AM_SP1      = 4'hC, // stack_offset8_mode
    COD_AM_SP2      = 4'hD, // stack_offset16_mode
    COD_AM_ILLEGAL  = 4'hF
  } cod_amode_t;

  typedef enum logic [2:0] {
    COD_BASE_NONE  = 3'h0,
    COD_BASE_INDEX = 3'h1,
    COD_BASE_STACK = 3'h2,
    COD_BASE_ZERO  = 3'h3
  } cod_base_t;

  // register transfer operations carried out here
  typedef enum logic [2:0] {
    COD_XF_NONE      = 3'h0,
    COD_XF_SP_TO_HX  = 3'h1,
    COD_XF_XL_TO_ACC = 3'h2,
    COD_XF_HX_TO_SP  = 3'h3,
    COD_XF_TRAP      = 3'h4
  } cod_xfer_t;

  typedef enum logic [3:0] {
    COD_ST_IDLE = 4'b0001,
    COD_ST_HI   = 4'b0010,
    COD_ST_LO   = 4'b0100,
    COD_ST_DONE = 4'b1000
  } cod_state_t;

  localparam logic [3:0] COD_ACC_CYCLES_1 = 4'h1;
  localparam logic [3:0] COD_XFER_CYCLES  = 4'h2;
  localparam logic [3:0] COD_STACK_EXTRA  = 4'h1;
  localparam logic [7:0] COD_TRAP_SP_DROP = 8'h05;
  localparam logic [15:0] COD_VECTOR_ADDR = 16'hFFFC;
endpackage

/* cod_rom.sv */
// Purpose: combinational table of rows 0 to 3, the transfer opcodes and the two moves
// Assumes: prefix already stripped by the caller
// Notes:   blank positions report illegal
`timescale 1ns/10ps
module cod_rom (
  input  wire logic [7:0]          i_opcode,
  input  wire logic                i_prefixed,
  output cod_pkg::cod_amode_t      o_amode,
  output logic [3:0]               o_cycles,
  output logic [2:0]               o_bytes,
  output logic                     o_illegal
);
  import cod_pkg::*;

  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = i_opcode[7:4];
  assign lo = i_opcode[3:0];

  always_comb begin
    o_amode   = COD_AM_ILLEGAL;
    o_cycles  = 4'h0;
    o_bytes   = 3'h0;
    o_illegal = 1'b1;
    if (i_prefixed) begin
      // within rows 0 to 3 the prefix reaches columns 6, D and E only
      if (hi == 4'h6 && lo <= 4'h3 && lo != 4'h2) begin
        o_amode = COD_AM_SP1;
        o_cycles = (lo == 4'h1) ? 4'h6 : 4'h5;
        o_bytes = (lo == 4'h1) ? 3'h4 : 3'h3;
        o_illegal = 1'b0;
      end else if (hi == 4'hD && lo <= 4'h3) begin
        o_amode = COD_AM_SP2;
        o_cycles = 4'h5;
        o_bytes = 3'h4;
        o_illegal = 1'b0;
      end else if (hi == 4'hE && lo <= 4'h3) begin
        o_amode = COD_AM_SP1;
        o_cycles = 4'h4;
        o_bytes = 3'h3;
        o_illegal = 1'b0;
      end
    end else if (lo <= 4'h3) begin
      o_illegal = 1'b0;
      case (hi)
        4'h0: begin
          o_amode = COD_AM_PAGE0; o_cycles = 4'h5; o_bytes = 3'h3;
        end
        4'h1: begin
          o_amode = COD_AM_PAGE0; o_cycles = 4'h4; o_bytes = 3'h2;
        end
        4'h2: begin
          o_amode = COD_AM_REL; o_cycles = 4'h3; o_bytes = 3'h2;
          o_illegal = (lo >= 4'h2);
        end
        4'h3: begin
          o_amode = COD_AM_PAGE0; o_bytes = (lo == 4'h1) ? 3'h3 : 3'h2;
          o_cycles = (lo == 4'h1) ? 4'h5 : 4'h4;
          o_illegal = (lo >= 4'h2);
        end
        4'h4: begin
          o_amode = (lo == 4'h1) ? COD_AM_LITERAL : COD_AM_NONE;
          o_bytes = (lo == 4'h1) ? 3'h3 : 3'h1;
          o_cycles = (lo == 4'h1 || lo == 4'h2) ? ((lo == 4'h1) ? 4'h4 : 4'h5) : 4'h1;
        end
        4'h5: begin
          o_amode = (lo == 4'h1) ? COD_AM_LITERAL : COD_AM_NONE;
          o_bytes = (lo == 4'h1) ? 3'h3 : 3'h1;
          o_cycles = (lo == 4'h1) ? 4'h4 : ((lo == 4'h2) ? 4'h7 : 4'h1);
        end
        4'h6: begin
          o_amode = (lo == 4'h1) ? COD_AM_IX1P : ((lo == 4'h0) ? COD_AM_IX1 : COD_AM_NONE);
          o_bytes = (lo == 4'h1) ? 3'h3 : ((lo == 4'h0) ? 3'h2 : 3'h1);
          o_cycles = (lo == 4'h2) ? 4'h3 : ((lo == 4'h1) ? 4'h5 : 4'h4);
          o_illegal = (lo == 4'h3);
        end
        4'h7: begin
          o_amode = (lo == 4'h1) ? COD_AM_IXP : ((lo == 4'h2) ? COD_AM_NONE : COD_AM_IX);
          o_bytes = (lo == 4'h1) ? 3'h2 : 3'h1;
          o_cycles = (lo == 4'h1) ? 4'h4 : ((lo == 4'h2) ? 4'h2 : 4'h3);
        end
        4'h8: begin
          o_amode = COD_AM_NONE; o_bytes = 3'h1;
          o_cycles = (lo == 4'h0) ? 4'h7 : ((lo == 4'h1) ? 4'h4 : 4'h9);
          o_illegal = (lo == 4'h2);
        end
        4'h9: begin
          o_amode = COD_AM_REL; o_cycles = 4'h3; o_bytes = 3'h2;
          o_illegal = (lo == 4'h3);
        end
        4'hA: begin
          o_amode = COD_AM_LITERAL; o_cycles = 4'h2; o_bytes = 3'h2;
          o_illegal = (lo != 4'h0);
        end
        4'hB: begin
          o_amode = COD_AM_PAGE0; o_cycles = 4'h3; o_bytes = 3'h2;
          o_illegal = (lo == 4'h3);
        end
        4'hC: begin
          o_amode = COD_AM_FULL; o_cycles = 4'h4; o_bytes = 3'h3;
          o_illegal = (lo == 4'h3);
        end
        4'hD: begin
          o_amode = COD_AM_IX2; o_cycles = 4'h4; o_bytes = 3'h3;
        end
        4'hE: begin
          o_amode = COD_AM_IX1; o_cycles = 4'h3; o_bytes = 3'h2;
          o_illegal = (lo >= 4'h2);
        end
        4'hF: begin
          o_amode = COD_AM_IX; o_cycles = 4'h2; o_bytes = 3'h1;
        end
        default: begin
          o_illegal = 1'b1;
        end
      endcase
    end
    if (!i_prefixed) begin
      case (i_opcode)
        OPC_STACK_TO_INDEX, OPC_INDEX_TO_STACK: begin
          o_amode = COD_AM_NONE; o_cycles = COD_XFER_CYCLES; o_bytes = 3'h1;
          o_illegal = 1'b0;
        end
        OPC_INDEX_LOW_TO_ACC: begin
          o_amode = COD_AM_NONE; o_cycles = COD_ACC_CYCLES_1; o_bytes = 3'h1;
          o_illegal = 1'b0;
        end
        OPC_MOV_LIT_DIR: begin
          o_amode = COD_AM_LIT_DIR; o_cycles = 4'h4; o_bytes = 3'h3;
          o_illegal = 1'b0;
        end
        OPC_MOV_IXP_DIR: begin
          o_amode = COD_AM_IXP_DIR; o_cycles = 4'h4; o_bytes = 3'h2;
          o_illegal = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end
endmodule // cod_rom

/* cod_tb.sv */
// Purpose: self-checking bench for the opcode decode slice
// Assumes: one o_done pulse per instruction, inputs driven 1 ns after the edge
// Notes:   effective address is checked only where the operand order is unambiguous
`timescale 1ns/10ps
module testbench;
  import cod_pkg::*;
  logic        i_clk_sys;
  logic        i_rst;
  logic        i_byte_vld;
  logic [7:0]  i_byte;
  logic [15:0] i_index_pair;
  logic [15:0] i_stack_ptr;
  cod_amode_t  o_amode;
  cod_base_t   o_base;
  cod_xfer_t   o_xfer;
  logic [7:0]  o_opcode;
  logic [3:0]  o_cycles;
  logic [2:0]  o_bytes;
  logic [15:0] o_eff_addr;
  logic [15:0] o_xfer_value;
  logic [7:0]  o_dest_addr;
  logic        o_index_inc;
  logic        o_set_irq_mask;
  logic        o_flags_keep;
  logic        o_illegal;
  logic        o_done;
  int          err_count = 0;
  int          compares = 0;
  int          cyc = 0;
  localparam int MAX_CYC = 20000;
  // {prefix, opcode}
  logic [8:0]  tbl [0:25] = '{9'h095, 9'h09F, 9'h094, 9'h000, 9'h010, 9'h042, 9'h052,
    9'h080, 9'h083, 9'h031, 9'h041, 9'h0D0, 9'h0C0, 9'h071, 9'h061, 9'h06E, 9'h07E,
    9'h1E0, 9'h1D0, 9'h022, 9'h032, 9'h0A1, 9'h0C3, 9'h020, 9'h070, 9'h161};

  cod_decode i_dut (
    .i_clk_sys      (i_clk_sys),
    .i_rst          (i_rst),
    .i_byte_vld     (i_byte_vld),
    .i_byte         (i_byte),
    .i_index_pair   (i_index_pair),
    .i_stack_ptr    (i_stack_ptr),
    .o_amode        (o_amode),
    .o_base         (o_base),
    .o_xfer         (o_xfer),
    .o_opcode       (o_opcode),
    .o_cycles       (o_cycles),
    .o_bytes        (o_bytes),
    .o_eff_addr     (o_eff_addr),
    .o_xfer_value   (o_xfer_value),
    .o_dest_addr    (o_dest_addr),
    .o_index_inc    (o_index_inc),
    .o_set_irq_mask (o_set_irq_mask),
    .o_flags_keep   (o_flags_keep),
    .o_illegal      (o_illegal),
    .o_done         (o_done)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      err_count++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error: %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // {amode, bytes, cycles, illegal}; zero bytes or cycles means not checked
  function automatic logic [11:0] exp_of(input logic [8:0] k);
    case (k)
      9'h095, 9'h094: return {COD_AM_NONE, 3'h1, 4'h2, 1'b0};
      9'h09F: return {COD_AM_NONE, 3'h1, 4'h1, 1'b0};
      9'h000, 9'h031: return {COD_AM_PAGE0, 3'h3, 4'h5, 1'b0};
      9'h010: return {COD_AM_PAGE0, 3'h2, 4'h4, 1'b0};
      9'h042: return {COD_AM_NONE, 3'h1, 4'h5, 1'b0};
      9'h052, 9'h080: return {COD_AM_NONE, 3'h1, 4'h7, 1'b0};
      9'h083: return {COD_AM_NONE, 3'h1, 4'h9, 1'b0};
      9'h041: return {COD_AM_LITERAL, 3'h3, 4'h4, 1'b0};
      9'h0D0: return {COD_AM_IX2, 3'h3, 4'h4, 1'b0};
      9'h0C0: return {COD_AM_FULL, 3'h3, 4'h4, 1'b0};
      9'h071: return {COD_AM_IXP, 3'h2, 4'h0, 1'b0};
      9'h061: return {COD_AM_IX1P, 3'h3, 4'h5, 1'b0};
      9'h06E: return {COD_AM_LIT_DIR, 3'h3, 4'h4, 1'b0};
      9'h07E: return {COD_AM_IXP_DIR, 3'h2, 4'h4, 1'b0};
      9'h1E0: return {COD_AM_SP1, 3'h3, 4'h4, 1'b0};
      9'h1D0: return {COD_AM_SP2, 3'h4, 4'h5, 1'b0};
      9'h161: return {COD_AM_SP1, 3'h4, 4'h6, 1'b0};
      9'h020: return {COD_AM_REL, 3'h2, 4'h3, 1'b0};
      9'h070: return {COD_AM_IX, 3'h1, 4'h3, 1'b0};
      default: return {COD_AM_ILLEGAL, 3'h0, 4'h0, 1'b1};
    endcase
  endfunction

  // {valid, address}
  function automatic logic [16:0] exp_eff(input logic [8:0] k, input logic [15:0] hx,
                                          input logic [15:0] sp, input logic [7:0] b1,
                                          input logic [7:0] b2);
    case (k)
      9'h0D0: return {1'b1, 16'(hx + {b1, b2})};
      9'h0C0: return {1'b1, b1, b2};
      9'h071, 9'h070: return {1'b1, hx};
      9'h061: return {1'b1, 16'(hx + {8'h00, b1})};
      9'h000, 9'h010, 9'h031: return {1'b1, 8'h00, b1};
      9'h1E0, 9'h161: return {1'b1, 16'(sp + {8'h00, b1})};
      9'h1D0: return {1'b1, 16'(sp + {b1, b2})};
      default: return 17'h0_0000;
    endcase
  endfunction

  task automatic put(input logic v, input logic [7:0] b);
    i_byte_vld = v;
    i_byte = b;
    @(posedge i_clk_sys);
    #1;
  endtask

  task automatic run(input logic [8:0] k, input logic [15:0] hx, input logic [15:0] sp,
                     input logic [7:0] b1, input logic [7:0] b2);
    logic [11:0] e;
    logic [16:0] ea;
    int          n;
    int          w;
    e = exp_of(k);
    ea = exp_eff(k, hx, sp, b1, b2);
    n = (e[7:5] == 3'h0) ? 0 : int'(e[7:5]) - 1 - int'(k[8]);
    i_index_pair = hx;
    i_stack_ptr = sp;
    if (k[8]) put(1'b1, OPC_STACK_PREFIX);
    put(1'b1, k[7:0]);
    put(1'b0, 8'h00);
    // operands go high byte first
    if (n > 0) put(1'b1, b1);
    if (n > 1) put(1'b1, b2);
    i_byte_vld = 1'b0;
    w = 0;
    while (o_done !== 1'b1 && w < 20) begin
      @(posedge i_clk_sys);
      #1;
      w++;
    end
    chk("done", 16'(o_done), 16'h0001);
    chk("opcode", 16'(o_opcode), {8'h00, k[7:0]});
    chk("amode", 16'(o_amode), {12'h000, e[11:8]});
    chk("illegal", 16'(o_illegal), {15'h0000, e[0]});
    if (e[7:5] != 3'h0) chk("bytes", 16'(o_bytes), {13'h0000, e[7:5]});
    if (e[4:1] != 4'h0) chk("cycles", 16'(o_cycles), {12'h000, e[4:1]});
    if (ea[16]) chk("eff_addr", o_eff_addr, ea[15:0]);
    if (k[8]) chk("base", 16'(o_base), 16'(COD_BASE_STACK));
    chk("index_inc", 16'(o_index_inc), 16'(k == 9'h071 || k == 9'h061 || k == 9'h07E));
    chk("irq_flag", 16'(o_set_irq_mask), 16'(k == 9'h083));
    case (k)
      9'h095: begin
        chk("xfer", 16'(o_xfer), 16'(COD_XF_SP_TO_HX));
        chk("xfer_value", o_xfer_value, 16'(sp + 16'h0001));
        chk("flags_keep", 16'(o_flags_keep), 16'h0001);
      end
      9'h094: begin
        chk("xfer", 16'(o_xfer), 16'(COD_XF_HX_TO_SP));
        chk("xfer_value", o_xfer_value, 16'(hx - 16'h0001));
        chk("flags_keep", 16'(o_flags_keep), 16'h0001);
      end
      9'h09F: begin
        chk("xfer", 16'(o_xfer), 16'(COD_XF_XL_TO_ACC));
        chk("xfer_value", o_xfer_value, {8'h00, hx[7:0]});
      end
      9'h083: begin
        chk("xfer", 16'(o_xfer), 16'(COD_XF_TRAP));
        chk("vector", o_xfer_value, COD_VECTOR_ADDR);
        chk("irq_mask", 16'(o_set_irq_mask), 16'h0001);
      end
      9'h06E: begin
        chk("literal", {8'h00, o_eff_addr[7:0]}, {8'h00, b1});
        chk("dest", {8'h00, o_dest_addr}, {8'h00, b2});
      end
      9'h07E: chk("dest", {8'h00, o_dest_addr}, {8'h00, b1});
      default: ;
    endcase
  endtask

  initial begin
    i_rst = 1'b1;
    i_byte_vld = 1'b0;
    i_byte = 8'h00;
    i_index_pair = 16'h0000;
    i_stack_ptr = 16'h0000;
    void'($urandom(26510));
    repeat (5) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    chk("rst_done", 16'(o_done), 16'h0000);
    chk("rst_amode", 16'(o_amode), 16'(COD_AM_NONE));
    // pass 0 holds the wrap corners, later passes random order and values
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 26; i++) begin
        if (p == 0) begin
          run(tbl[i], 16'h0000, 16'hFFFF, 8'hFF, 8'hFF);
        end else begin
          run(tbl[$urandom_range(25, 0)], 16'($urandom), 16'($urandom), 8'($urandom),
              8'($urandom));
        end
      end
      $display("test pass %0d finished", p);
    end
    // reset in mid-run must clear the held trap outputs
    run(9'h083, 16'h1234, 16'h00FF, 8'h00, 8'h00);
    i_rst = 1'b1;
    @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    chk("rst_irq_mask", 16'(o_set_irq_mask), 16'h0000);
    chk("rst_cycles", 16'(o_cycles), 16'h0000);
    $display("test mid reset finished");
    results();
  end
endmodule // testbench
